// [sim/pcc_assertions.sv]
// Port-level checks for the PLL configuration control block
`timescale 1ns/10ps
`default_nettype none
module pcc_assertions
    import pcc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              pclk,            // Clock
    input wire logic              presetn,         // Reset
    input wire logic              psel,            // Select
    input wire logic              penable,         // Enable
    input wire logic              pwrite,          // Direction
    input wire logic [ADDR_W-1:0] paddr,           // Address
    input wire logic [31:0]       pwdata,          // Write data
    input wire logic [31:0]       prdata,          // Read data
    input wire logic              pready,          // Ready
    input wire logic              pslverr,         // Error
    input wire logic              ref_pulse,       // R pulse
    input wire logic              fb_pulse,        // N pulse
    input wire logic              pll_power_down,  // PLL off
    input wire logic              dist_src_vco,    // VCO source
    input wire logic              div_bypass,      // Bypass
    input wire logic [2:0]        vco_div_ratio,   // Ratio
    input wire logic [1:0]        abl_width,       // Antibacklash
    input wire logic [2:0]        cp_current_code, // Current code
    input wire logic [12:0]       cp_current_ua,   // Current uA
    input wire logic              pump_up,         // Up
    input wire logic              pump_down,       // Down
    input wire logic              pump_hiz,        // High impedance
    input wire logic              cal_busy,        // Cal running
    input wire logic              cal_done         // Cal finished
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic       upd_go;
    logic [3:0] since_upd_q;
    logic [3:0] since_upd_d;

    assign upd_go = psel && penable && pwrite && paddr[ADDR_W-1:2] == PCC_IDX_UPDATE && pwdata[7:0] == PCC_UPDATE_GO;

    // Saturating age of the last update
    always_comb begin
        since_upd_d = since_upd_q;
        if (upd_go) since_upd_d = 4'h0;
        else if (since_upd_q != 4'hF) since_upd_d = since_upd_q + 4'h1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) since_upd_q <= 4'hF;
        else since_upd_q <= since_upd_d;
    end

    a_update_only: assert property (
        !$stable({pll_power_down, dist_src_vco, div_bypass, vco_div_ratio, abl_width, cp_current_code})
        |-> $past(upd_go)) else $error("active setting changed without update");
    a_ratio_range: assert property (
        vco_div_ratio inside {[3'h2:3'h6]}) else $error("divide ratio out of range");
    a_current_step: assert property (
        cp_current_ua == 13'h258 * ({10'h0, cp_current_code} + 13'h1)) else $error("pump current wrong");
    a_off_hiz: assert property (
        pll_power_down [*2] |-> pump_hiz && !pump_up && !pump_down) else $error("pump active while PLL off");
    a_hiz_quiet: assert property (
        pump_hiz |-> !pump_up && !pump_down) else $error("pump drives while high impedance");
    a_cal_excl: assert property (
        !(cal_busy && cal_done)) else $error("calibration busy and done together");
    a_done_cause: assert property (
        $rose(cal_done) |-> $past(cal_busy)) else $error("calibration done without run");
    a_start_cause: assert property (
        $rose(cal_busy) |-> since_upd_q <= 4'h4) else $error("calibration started without update");

    c_cal_done: cover property ($rose(cal_done));
    c_pump_up: cover property (pump_up && !pump_hiz);
    c_pump_down: cover property (pump_down && !pump_hiz);
    c_refused: cover property (pslverr);
endmodule
`default_nettype wire

// [sim/test_pcc_top.sv]
// Self-checking testbench for the PLL configuration control block
`timescale 1ns/10ps
`default_nettype none
module test_pcc_top
    import pcc_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, ref_pulse, fb_pulse;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, pll_power_down, dist_src_vco, div_bypass, pump_up, pump_down, pump_hiz;
    logic        cal_busy, cal_done, er;
    logic [2:0]  vco_div_ratio, cp_current_code;
    logic [1:0]  abl_width;
    logic [12:0] cp_current_ua;
    int          n_mismatch, checks_done, seed;
    logic [7:0]  stg [logic [9:0]];
    logic [7:0]  act [logic [9:0]];
    logic [7:0]  pm [10] = '{8'h00, 8'h10, 8'h20, 8'h11, 8'h30, 8'h30, 8'hB0, 8'hB0, 8'h70, 8'h12};
    logic [1:0]  pp [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h2, 2'h2, 2'h2, 2'h0};
    logic [2:0]  pe [10] = '{3'h1, 3'h4, 3'h2, 3'h1, 3'h4, 3'h2, 3'h2, 3'h4, 3'h1, 3'h1};

    pcc_top #(.CAL_CYCLES(4)) pcc_top_i (.*);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic known(input logic [9:0] ix);
        return stg.exists(ix) || ix == PCC_IDX_UPDATE || ix == PCC_IDX_STATUS;
    endfunction

    // Model: only the go value copies staging to active
    task automatic wr(input logic [9:0] ix, input logic [7:0] d);
        apb(1'b1, ix, d);
        cmp({31'h0, er}, {31'h0, !known(ix)});
        if (ix == PCC_IDX_UPDATE && d == PCC_UPDATE_GO) act = stg;
        else if (stg.exists(ix)) stg[ix] = d;
    endtask

    task automatic rdc(input logic [9:0] ix);
        apb(1'b0, ix, 8'h00);
        cmp(rd, stg.exists(ix) ? {24'h0, stg[ix]} : 32'h0);
        cmp({31'h0, er}, {31'h0, !known(ix)});
    endtask

    task automatic chk_out();
        logic [2:0] c;
        c = act[PCC_IDX_VCO_DIV][2:0];
        repeat (2) @(posedge pclk);
        #1;
        cmp({8'h0, pll_power_down, dist_src_vco, div_bypass, vco_div_ratio, abl_width, cp_current_code, cp_current_ua},
            {8'h0, act[PCC_IDX_PLL_MAIN][1:0] != 2'b00, act[PCC_IDX_ROUTE][1:0], (c > 3'h4) ? 3'h6 : c + 3'h2,
             act[PCC_IDX_ABL][1:0], act[PCC_IDX_CP_CUR][2:0], 13'h258 * ({10'h0, act[PCC_IDX_CP_CUR][2:0]} + 13'h1)});
    endtask

    task automatic pmp(input logic [7:0] m, input logic [7:0] rt, input logic r, input logic f, input logic [2:0] ex);
        wr(PCC_IDX_PLL_MAIN, m);
        wr(PCC_IDX_ROUTE, rt);
        wr(PCC_IDX_UPDATE, PCC_UPDATE_GO);
        chk_out();
        @(posedge pclk);
        ref_pulse <= r;
        fb_pulse <= f;
        @(posedge pclk);
        ref_pulse <= 1'b0;
        fb_pulse <= 1'b0;
        @(posedge pclk);
        #1;
        cmp({29'h0, pump_up, pump_down, pump_hiz}, {29'h0, ex});
        // Both edges together empty the detector before the next case
        @(posedge pclk);
        ref_pulse <= 1'b1;
        fb_pulse <= 1'b1;
        @(posedge pclk);
        ref_pulse <= 1'b0;
        fb_pulse <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask

    task automatic wcal(input logic [1:0] e);
        int n;
        n = 0;
        #1;
        while ({cal_busy, cal_done} !== e && n < 40) begin
            @(posedge pclk);
            n++;
        end
        #1;
        cmp({30'h0, cal_busy, cal_done}, {30'h0, e});
    endtask

    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        seed = 29942;
        {presetn, psel, penable, pwrite, ref_pulse, fb_pulse} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        stg[PCC_IDX_PLL_MAIN] = PCC_RST_PLL_MAIN;
        stg[PCC_IDX_ABL] = PCC_RST_ABL;
        stg[PCC_IDX_VCO_CAL] = PCC_RST_VCO_CAL;
        stg[PCC_IDX_VCO_DIV] = PCC_RST_VCO_DIV;
        stg[PCC_IDX_ROUTE] = PCC_RST_ROUTE;
        stg[PCC_IDX_CP_CUR] = PCC_RST_CP_CUR;
        act = stg;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (stg[i]) rdc(i);
        chk_out();
        rdc(10'h3FF);
        wr(10'h3FF, 8'hA5);
        wr(PCC_IDX_ROUTE, 8'h03);
        rdc(PCC_IDX_ROUTE);
        chk_out();
        wr(PCC_IDX_UPDATE, 8'h02);
        chk_out();
        rdc(PCC_IDX_UPDATE);
        wr(PCC_IDX_UPDATE, PCC_UPDATE_GO);
        chk_out();
        for (int k = 0; k < 8; k++) begin
            wr(PCC_IDX_VCO_DIV, 8'(k));
            wr(PCC_IDX_CP_CUR, 8'(7 - k));
            wr(PCC_IDX_ABL, 8'($random(seed)));
            wr(PCC_IDX_ROUTE, 8'($random(seed)));
            wr(PCC_IDX_PLL_MAIN, 8'($random(seed)));
            wr(PCC_IDX_UPDATE, PCC_UPDATE_GO);
            chk_out();
        end
        wr(PCC_IDX_ABL, 8'h03);
        for (int i = 0; i < 10; i++) pmp(pm[i], {6'h0, i == 7, 1'b0}, pp[i][1], pp[i][0], pe[i]);
        // Calibration with the internal source and PLL running
        wr(PCC_IDX_VCO_DIV, 8'h02);
        pmp(8'h30, 8'h02, 1'b0, 1'b0, 3'h0);
        wr(PCC_IDX_VCO_CAL, 8'h01);
        wr(PCC_IDX_UPDATE, PCC_UPDATE_GO);
        wcal(2'b10);
        wcal(2'b01);
        wr(PCC_IDX_VCO_CAL, 8'h00);
        wr(PCC_IDX_UPDATE, PCC_UPDATE_GO);
        wcal(2'b00);
        wr(PCC_IDX_VCO_CAL, 8'h01);
        wr(PCC_IDX_UPDATE, PCC_UPDATE_GO);
        wcal(2'b10);
        wcal(2'b01);
        give_verdict();
    end
endmodule

bind pcc_top pcc_assertions #(.ADDR_W(ADDR_W)) pcc_assertions_i (.*);
`default_nettype wire

// [src/pcc_pfd_cp.sv]
// Phase frequency detector with antibacklash and charge-pump command stage
`timescale 1ns/10ps
`default_nettype none
module pcc_pfd_cp
    import pcc_pkg::*;
(
    input  wire logic       pclk,       // Clock
    input  wire logic       presetn,    // Async reset, active low
    input  wire logic       pll_on,     // PLL in normal operation
    input  wire logic       ref_pulse,  // R counter output edge
    input  wire logic       fb_pulse,   // N counter output edge
    input  wire logic [1:0] abl_code,   // Antibacklash width code
    input  wire logic [2:0] cp_mode,    // Charge-pump mode code
    input  wire logic       invert,     // Effective negative polarity
    output logic            pump_up,    // Pump up command
    output logic            pump_down,  // Pump down command
    output logic            pump_hiz    // Pump output high impedance
);
    logic       up_q;
    logic       up_d;
    logic       dn_q;
    logic       dn_d;
    logic [1:0] abl_q;
    logic [1:0] abl_d;
    logic       pu_q;
    logic       pu_d;
    logic       pd_q;
    logic       pd_d;
    logic       hz_q;
    logic       hz_d;

    always_comb begin
        up_d  = up_q;
        dn_d  = dn_q;
        abl_d = abl_q;
        if (!pll_on) begin
            up_d  = 1'b0;
            dn_d  = 1'b0;
            abl_d = 2'b00;
        end else begin
            if (ref_pulse) begin
                up_d = 1'b1; // [RULE_13]
            end
            if (fb_pulse) begin
                dn_d = 1'b1; // [RULE_13]
            end
            // Both sides held for code+1 cycles so there is no dead zone
            if (up_q && dn_q) begin
                if (abl_q == abl_code) begin
                    up_d  = 1'b0; // [RULE_10]
                    dn_d  = 1'b0;
                    abl_d = 2'b00;
                end else begin
                    abl_d = abl_q + 2'b01;
                end
            end
        end
        pu_d = 1'b0;
        pd_d = 1'b0;
        hz_d = 1'b1;
        if (pll_on) begin
            unique case (cp_mode)
                PCC_CP_NORMAL: begin
                    pu_d = invert ? dn_q : up_q; // [RULE_08]
                    pd_d = invert ? up_q : dn_q;
                    hz_d = 1'b0;
                end
                PCC_CP_UP: begin
                    pu_d = 1'b1; // [RULE_11]
                    hz_d = 1'b0;
                end
                PCC_CP_DOWN: begin
                    pd_d = 1'b1; // [RULE_11]
                    hz_d = 1'b0;
                end
                default: begin
                    hz_d = 1'b1; // [RULE_11]
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_q  <= 1'b0;
            dn_q  <= 1'b0;
            abl_q <= 2'b00;
            pu_q  <= 1'b0;
            pd_q  <= 1'b0;
            hz_q  <= 1'b1;
        end else begin
            up_q  <= up_d;
            dn_q  <= dn_d;
            abl_q <= abl_d;
            pu_q  <= pu_d;
            pd_q  <= pd_d;
            hz_q  <= hz_d;
        end
    end

    assign pump_up   = pu_q;
    assign pump_down = pd_q;
    assign pump_hiz  = hz_q;
endmodule
`default_nettype wire

// [src/pcc_pkg.sv]
// Package: register map, field layout, reset values and encodings of the PLL configuration control
package pcc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [9:0] PCC_IDX_PLL_MAIN  = 10'h010;
    localparam logic [9:0] PCC_IDX_ABL       = 10'h017;
    localparam logic [9:0] PCC_IDX_VCO_CAL   = 10'h018;
    localparam logic [9:0] PCC_IDX_VCO_DIV   = 10'h1E0;
    localparam logic [9:0] PCC_IDX_ROUTE     = 10'h1E1;
    localparam logic [9:0] PCC_IDX_UPDATE    = 10'h232;
    localparam logic [9:0] PCC_IDX_CP_CUR    = 10'h0F0;
    localparam logic [9:0] PCC_IDX_STATUS    = 10'h0F1;

    // Field positions
    localparam int PCC_POWER_LSB   = 0;
    localparam int PCC_CPMODE_LSB  = 4;
    localparam int PCC_PFDPOL_BIT  = 7;
    localparam int PCC_ABL_LSB     = 0;
    localparam int PCC_CAL_BIT     = 0;
    localparam int PCC_DIV_LSB     = 0;
    localparam int PCC_BYPASS_BIT  = 0;
    localparam int PCC_SRCVCO_BIT  = 1;
    localparam int PCC_CPCUR_LSB   = 0;

    // Reset values
    localparam logic [7:0] PCC_RST_PLL_MAIN = 8'h01;
    localparam logic [7:0] PCC_RST_ABL      = 8'h00;
    localparam logic [7:0] PCC_RST_VCO_CAL  = 8'h00;
    localparam logic [7:0] PCC_RST_VCO_DIV  = 8'h02;
    localparam logic [7:0] PCC_RST_ROUTE    = 8'h00;
    localparam logic [7:0] PCC_RST_CP_CUR   = 8'h00;

    // Update trigger value
    localparam logic [7:0] PCC_UPDATE_GO    = 8'h01;

    // PLL power codes
    localparam logic [1:0] PCC_PWR_NORMAL   = 2'b00;
    localparam logic [1:0] PCC_PWR_ASYNC_PD = 2'b01;

    // VCO divider: ratio is code plus this offset, clamped at the maximum
    localparam logic [2:0] PCC_DIV_OFFSET   = 3'h2;
    localparam logic [2:0] PCC_DIV_MAX_CODE = 3'h4;

    // Charge-pump current step in microamps
    localparam logic [12:0] PCC_CP_STEP_UA  = 13'd600;

    // Calibration run length in pclk cycles
    localparam int PCC_CAL_CYCLES = 64;

    typedef enum logic [2:0] {
        PCC_CP_HIZ    = 3'b000,
        PCC_CP_UP     = 3'b001,
        PCC_CP_DOWN   = 3'b010,
        PCC_CP_NORMAL = 3'b011
    } pcc_cp_mode_t;

    typedef enum logic [1:0] {
        PCC_CAL_IDLE = 2'b00,
        PCC_CAL_RUN  = 2'b01,
        PCC_CAL_DONE = 2'b10
    } pcc_cal_state_t;

endpackage

// [src/pcc_top.sv]
// PLL configuration control: APB register file, staging/update, clock routing and PLL control
//
// Functional notes
// (RULE_01) Power code 00 runs the PLL; 01 is asynchronous power-down.
// (RULE_02) Bypass bit 1 feeds distribution directly; 0 goes through VCO divider.
// (RULE_03) Source bit 1 selects internal VCO; 0 selects external clock input.
// (RULE_04) Three-bit divider code selects ratio 2 to 6.
// (RULE_05) Applied calibrate rising to 1 starts calibration; applied 0 resets it.
// (RULE_06) Software clears and applies calibrate before every later recalibration.
// (RULE_07) Writes are staged; update written with 0x01 makes them active.
// (RULE_08) Polarity bit 0 positive, 1 negative.
// (RULE_09) Polarity only acts while the external VCO path is in use.
// (RULE_10) Two-bit field sets antibacklash pulse width.
// (RULE_11) Pump mode: high impedance, normal, forced up, forced down.
// (RULE_12) Eight pump current settings, 600 uA to 4.8 mA in equal steps.
// (RULE_13) PFD compares R and N outputs and commands pump up or down.
// (RULE_14) Reset: PLL off, divide by four, divider used, external clock selected.
// (RULE_15) Software keeps reference present and divider non-static while calibrating.
// (RULE_16) Fixed pump mode encoding; current code k gives (k+1) steps.
`timescale 1ns/10ps
`default_nettype none
module pcc_top
    import pcc_pkg::*;
#(
    parameter int ADDR_W     = 12,
    parameter int CAL_CYCLES = PCC_CAL_CYCLES
) (
    input  wire logic              pclk,            // APB clock
    input  wire logic              presetn,         // Async reset, active low
    input  wire logic              psel,            // APB select
    input  wire logic              penable,         // APB enable
    input  wire logic              pwrite,          // APB direction
    input  wire logic [ADDR_W-1:0] paddr,           // APB byte address
    input  wire logic [31:0]       pwdata,          // APB write data
    output logic [31:0]            prdata,          // APB read data
    output logic                   pready,          // APB ready
    output logic                   pslverr,         // APB error, unmapped address
    input  wire logic              ref_pulse,       // R counter output pulse
    input  wire logic              fb_pulse,        // N counter output pulse
    output logic                   pll_power_down,  // PLL powered down
    output logic                   dist_src_vco,    // Source is internal VCO
    output logic                   div_bypass,      // Distribution bypasses VCO divider
    output logic [2:0]             vco_div_ratio,   // Active VCO divide ratio
    output logic [1:0]             abl_width,       // Active antibacklash code
    output logic [2:0]             cp_current_code, // Active pump current code
    output logic [12:0]            cp_current_ua,   // Nominal pump current in uA
    output logic                   pump_up,         // Charge pump up
    output logic                   pump_down,       // Charge pump down
    output logic                   pump_hiz,        // Charge pump high impedance
    output logic                   cal_busy,        // VCO calibration running
    output logic                   cal_done         // VCO calibration finished
);
    // Staged and active copies of each of the six setting registers
    logic [7:0]  stg_main_q;
    logic [7:0]  stg_main_d;
    logic [7:0]  stg_abl_q;
    logic [7:0]  stg_abl_d;
    logic [7:0]  stg_cal_q;
    logic [7:0]  stg_cal_d;
    logic [7:0]  stg_div_q;
    logic [7:0]  stg_div_d;
    logic [7:0]  stg_route_q;
    logic [7:0]  stg_route_d;
    logic [7:0]  stg_cpi_q;
    logic [7:0]  stg_cpi_d;
    logic [7:0]  act_main_q;
    logic [7:0]  act_main_d;
    logic [7:0]  act_abl_q;
    logic [7:0]  act_abl_d;
    logic [7:0]  act_cal_q;
    logic [7:0]  act_cal_d;
    logic [7:0]  act_div_q;
    logic [7:0]  act_div_d;
    logic [7:0]  act_route_q;
    logic [7:0]  act_route_d;
    logic [7:0]  act_cpi_q;
    logic [7:0]  act_cpi_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        perr_q;
    logic        perr_d;
    logic        cal_start_q;
    logic        cal_start_d;
    logic        cal_clear_q;
    logic        cal_clear_d;

    logic [9:0]  idx;
    logic        setup_ph;
    logic        wr_en;
    logic        upd;
    logic        mapped;
    logic [7:0]  rd_val;
    logic [7:0]  status;
    logic        pll_on;
    logic [2:0]  div_code;
    logic [2:0]  cpi_code;
    logic        invert;

    assign idx      = paddr[11:2];
    assign setup_ph = psel && !penable;
    assign pready   = psel && penable;
    assign wr_en    = psel && penable && pwrite;
    assign upd      = wr_en && (idx == PCC_IDX_UPDATE) && (pwdata[7:0] == PCC_UPDATE_GO); // [RULE_07]

    assign status = {5'h00, pll_on, cal_done, cal_busy};

    // Address decode and read mux, sampled in the setup cycle
    always_comb begin
        mapped = 1'b1;
        rd_val = 8'h00;
        unique case (idx)
            PCC_IDX_PLL_MAIN: rd_val = stg_main_q;
            PCC_IDX_ABL:      rd_val = stg_abl_q;
            PCC_IDX_VCO_CAL:  rd_val = stg_cal_q;
            PCC_IDX_VCO_DIV:  rd_val = stg_div_q;
            PCC_IDX_ROUTE:    rd_val = stg_route_q;
            PCC_IDX_CP_CUR:   rd_val = stg_cpi_q;
            PCC_IDX_STATUS:   rd_val = status;
            PCC_IDX_UPDATE:   rd_val = 8'h00;
            default:          mapped = 1'b0;
        endcase
    end

    always_comb begin
        prdata_d = prdata_q;
        perr_d   = perr_q;
        if (setup_ph) begin
            prdata_d = {24'h000000, rd_val};
            perr_d   = !mapped;
        end
    end

    // Staging: software writes land here and steer nothing until an update
    always_comb begin
        stg_main_d  = stg_main_q;
        stg_abl_d   = stg_abl_q;
        stg_cal_d   = stg_cal_q;
        stg_div_d   = stg_div_q;
        stg_route_d = stg_route_q;
        stg_cpi_d   = stg_cpi_q;
        if (wr_en) begin
            unique case (idx)
                PCC_IDX_PLL_MAIN: stg_main_d  = pwdata[7:0]; // [RULE_07]
                PCC_IDX_ABL:      stg_abl_d   = pwdata[7:0];
                PCC_IDX_VCO_CAL:  stg_cal_d   = pwdata[7:0];
                PCC_IDX_VCO_DIV:  stg_div_d   = pwdata[7:0];
                PCC_IDX_ROUTE:    stg_route_d = pwdata[7:0];
                PCC_IDX_CP_CUR:   stg_cpi_d   = pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // Update: copy staging to active, and derive calibration commands
    always_comb begin
        act_main_d  = act_main_q;
        act_abl_d   = act_abl_q;
        act_cal_d   = act_cal_q;
        act_div_d   = act_div_q;
        act_route_d = act_route_q;
        act_cpi_d   = act_cpi_q;
        cal_start_d = 1'b0;
        cal_clear_d = 1'b0;
        if (upd) begin
            act_main_d  = stg_main_q; // [RULE_07]
            act_abl_d   = stg_abl_q;
            act_cal_d   = stg_cal_q;
            act_div_d   = stg_div_q;
            act_route_d = stg_route_q;
            act_cpi_d   = stg_cpi_q;
            // A second start needs a cleared bit applied first
            cal_start_d = stg_cal_q[PCC_CAL_BIT] && !act_cal_q[PCC_CAL_BIT]; // [RULE_05] [RULE_06]
            cal_clear_d = !stg_cal_q[PCC_CAL_BIT]; // [RULE_05]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stg_main_q  <= PCC_RST_PLL_MAIN; // [RULE_14]
            stg_abl_q   <= PCC_RST_ABL;
            stg_cal_q   <= PCC_RST_VCO_CAL;
            stg_div_q   <= PCC_RST_VCO_DIV;
            stg_route_q <= PCC_RST_ROUTE;
            stg_cpi_q   <= PCC_RST_CP_CUR;
            act_main_q  <= PCC_RST_PLL_MAIN; // [RULE_14]
            act_abl_q   <= PCC_RST_ABL;
            act_cal_q   <= PCC_RST_VCO_CAL;
            act_div_q   <= PCC_RST_VCO_DIV;
            act_route_q <= PCC_RST_ROUTE;
            act_cpi_q   <= PCC_RST_CP_CUR;
            prdata_q    <= 32'h00000000;
            perr_q      <= 1'b0;
            cal_start_q <= 1'b0;
            cal_clear_q <= 1'b0;
        end else begin
            stg_main_q  <= stg_main_d;
            stg_abl_q   <= stg_abl_d;
            stg_cal_q   <= stg_cal_d;
            stg_div_q   <= stg_div_d;
            stg_route_q <= stg_route_d;
            stg_cpi_q   <= stg_cpi_d;
            act_main_q  <= act_main_d;
            act_abl_q   <= act_abl_d;
            act_cal_q   <= act_cal_d;
            act_div_q   <= act_div_d;
            act_route_q <= act_route_d;
            act_cpi_q   <= act_cpi_d;
            prdata_q    <= prdata_d;
            perr_q      <= perr_d;
            cal_start_q <= cal_start_d;
            cal_clear_q <= cal_clear_d;
        end
    end

    assign prdata  = prdata_q;
    assign pslverr = pready && perr_q;

    // Codes 10 and 11 are treated as powered down to fail safe
    assign pll_on         = (act_main_q[PCC_POWER_LSB +: 2] == PCC_PWR_NORMAL); // [RULE_01]
    assign pll_power_down = !pll_on; // [RULE_01]
    assign dist_src_vco   = act_route_q[PCC_SRCVCO_BIT]; // [RULE_03]
    assign div_bypass     = act_route_q[PCC_BYPASS_BIT]; // [RULE_02]

    // Illegal divider codes clamp to the largest ratio so the divider never goes static
    assign div_code      = act_div_q[PCC_DIV_LSB +: 3];
    assign vco_div_ratio = ((div_code > PCC_DIV_MAX_CODE) ? PCC_DIV_MAX_CODE : div_code) + PCC_DIV_OFFSET; // [RULE_04]

    assign abl_width       = act_abl_q[PCC_ABL_LSB +: 2]; // [RULE_10]
    assign cpi_code        = act_cpi_q[PCC_CPCUR_LSB +: 3];
    assign cp_current_code = cpi_code; // [RULE_12]
    assign cp_current_ua   = PCC_CP_STEP_UA * ({10'h000, cpi_code} + 13'h0001); // [RULE_16]

    // Polarity is meaningless with the internal VCO, whose sense is fixed
    assign invert = act_main_q[PCC_PFDPOL_BIT] && !dist_src_vco; // [RULE_09]

    pcc_pfd_cp u_pfd_cp (
        .pclk      (pclk),
        .presetn   (presetn),
        .pll_on    (pll_on),
        .ref_pulse (ref_pulse),
        .fb_pulse  (fb_pulse),
        .abl_code  (abl_width),
        .cp_mode   (act_main_q[PCC_CPMODE_LSB +: 3]),
        .invert    (invert),
        .pump_up   (pump_up),
        .pump_down (pump_down),
        .pump_hiz  (pump_hiz)
    );

    pcc_vco_cal #(
        .CAL_CYCLES (CAL_CYCLES)
    ) u_vco_cal (
        .pclk      (pclk),
        .presetn   (presetn),
        .cal_start (cal_start_q),
        .cal_clear (cal_clear_q),
        .run_en    (pll_on),
        .cal_busy  (cal_busy),
        .cal_done  (cal_done)
    );
endmodule
`default_nettype wire

// [src/pcc_vco_cal.sv]
// VCO calibration sequencer
`timescale 1ns/10ps
`default_nettype none
module pcc_vco_cal
    import pcc_pkg::*;
#(
    parameter int CAL_CYCLES = PCC_CAL_CYCLES
) (
    input  wire logic pclk,       // Clock
    input  wire logic presetn,    // Async reset, active low
    input  wire logic cal_start,  // One-cycle start request
    input  wire logic cal_clear,  // One-cycle calibration reset
    input  wire logic run_en,     // PLL powered, calibration may advance
    output logic      cal_busy,   // Calibration running
    output logic      cal_done    // Calibration finished
);
    pcc_cal_state_t state_q;
    pcc_cal_state_t state_d;
    logic [15:0]    cnt_q;
    logic [15:0]    cnt_d;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        if (cal_clear) begin
            state_d = PCC_CAL_IDLE; // [RULE_05]
            cnt_d   = 16'h0000;
        end else begin
            unique case (state_q)
                PCC_CAL_IDLE: begin
                    if (cal_start) begin
                        state_d = PCC_CAL_RUN; // [RULE_05]
                        cnt_d   = 16'h0000;
                    end
                end
                PCC_CAL_RUN: begin
                    // Pauses while the PLL is down rather than aborting
                    if (run_en) begin
                        if (cnt_q == 16'(CAL_CYCLES - 1)) begin
                            state_d = PCC_CAL_DONE;
                        end else begin
                            cnt_d = cnt_q + 16'h0001;
                        end
                    end
                end
                // A new start is ignored here until software clears the calibration
                PCC_CAL_DONE: begin
                end
                default: begin
                    state_d = PCC_CAL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= PCC_CAL_IDLE;
            cnt_q   <= 16'h0000;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    assign cal_busy = (state_q == PCC_CAL_RUN);
    assign cal_done = (state_q == PCC_CAL_DONE);
endmodule
`default_nettype wire
